// ===== pms_defs.svh
// constants of the per-channel management register set
// assumes a 125 MHz ref_clk and an mdio pin pair sampled on that clock
//
// Summary of operation
// R1: unsupported and reserved status and advert bits read zero, ignore writes
// R2: status bit 14 always reads one, writes have no effect
// R3: status bit 8 reads one, extended status lives at address 0x0F; no register is decoded there, it reads zero
// R4: status bit 6 reads one; frames without preamble are accepted
// R5: status bit 5 shows negotiation finished, reset value zero
// R6: status bit 4, remote fault, always reads zero
// R7: status bit 3 reads one, channel can negotiate, writes discarded
// R8: in 1000Base-X, status bit 2 shows link after negotiation, latches low
// R9: in 100Base-FX, link bit mirrors the link monitor output
// R10: deep or shallow loopback force link bit to one; remote keeps meaning
// R11: latched-low link holds zero after loss until read, then tracks again
// R12: status bit 0 reads one, extended registers are implemented
// R13: identifier built from maker id bits 3 to 24 over registers 2 and 3
// R14: register 3 holds model in bits 9:4, revision in 3:0, read-only
// R15: self-clearing reset bit returns to zero on the next mdc cycle
// R16: advert bit 15 next page, read-write, resets to zero, advertised
// R17: advert bits 13:12 remote fault code, read-write, reset 00, advertised
// R18: advert bits 8:5 technology ability, read-write, reset 0001
// R19: in sgmii mode a fixed ability value is advertised instead
// R20: deep loopback is control bit 14 or the loopback pin, ored
`ifndef PMS_DEFS_SVH
`define PMS_DEFS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define PMS_REG_CONTROL   5'h00
`define PMS_REG_STATUS    5'h01
`define PMS_REG_ID_HIGH   5'h02
`define PMS_REG_ID_LOW    5'h03
`define PMS_REG_ADVERT    5'h04

// ****************************************************************
// field positions and fixed values
// ****************************************************************
`define PMS_CTL_RESET_BIT 15
`define PMS_CTL_LOOP_BIT  14
`define PMS_STAT_FIXED    16'h4149
`define PMS_STAT_DONE_BIT 5
`define PMS_STAT_LINK_BIT 2
`define PMS_ADV_WMASK     16'hB1E0
`define PMS_ADV_RESET     16'h0020
`define PMS_ADV_SGMII     16'h4001

// ****************************************************************
// frame fields
// ****************************************************************
`define PMS_OP_READ       2'h2
`define PMS_OP_WRITE      2'h1
`define PMS_HDR_LAST      5'h0B
`define PMS_WR_LAST       5'h11
`define PMS_RD_LAST       5'h10

`endif

// ===== pms_pkg.sv
// types shared by the management register set
// assumes pms_defs.svh supplies the numbers
`default_nettype none
package pms_pkg;

    typedef enum logic [2:0] {
        PMS_IDLE,
        PMS_START,
        PMS_HDR,
        PMS_TA,
        PMS_RDATA,
        PMS_WDATA
    } pms_mdio_st_e;

    typedef struct packed {
        logic s1;
        logic s2;
    } pms_sync_s;

    typedef struct packed {
        logic lat;
    } pms_latch_s;

endpackage
`default_nettype wire

// ===== pms_sync_2ff.sv
// two-flop synchroniser for one pin
// assumes the pin is asynchronous to ref_clk
`timescale 1ns/10ps
`default_nettype none
module pms_sync_2ff (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic pin_in,
    output logic      pin_sync
);
    pms_pkg::pms_sync_s st_r;
    pms_pkg::pms_sync_s st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = pin_in;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pin_sync = st_r.s2;
endmodule
`default_nettype wire

// ===== pms_link_latch.sv
// latched-low link status bit
// assumes rd_clr pulses once when the status word is taken for a read
`timescale 1ns/10ps
`default_nettype none
module pms_link_latch (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic link_raw,
    input  wire logic rd_clr,
    output logic      link_lat
);
    pms_pkg::pms_latch_s st_r;
    pms_pkg::pms_latch_s st_nxt;

    // a loss in the read cycle still wins: raw low gives zero either way
    always_comb begin
        st_nxt = st_r;
        if (rd_clr) begin
            st_nxt.lat = link_raw; // R11
        end else begin
            st_nxt.lat = st_r.lat & link_raw; // R8
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign link_lat = st_r.lat;

    chk_latch_holds_low: assert property ( // R8
        @(posedge ref_clk) disable iff (!rst_n)
        !link_raw |=> !link_lat) else $error("link loss not latched");
    chk_latch_rearm: assert property ( // R11
        @(posedge ref_clk) disable iff (!rst_n)
        (!link_lat && !rd_clr) |=> !link_lat)
        else $error("latched low released without read");
endmodule
`default_nettype wire

// ===== pms_mgmt_regs.sv
// management register set of one channel behind an mdio slave
// assumes mdc, mdio and loopback_pin come from pins; other inputs are ref_clk logic
`timescale 1ns/10ps
`default_nettype none
`include "pms_defs.svh"
module pms_mgmt_regs #(
    parameter logic [4:0]  PHY_ADDR  = 5'h00,
    parameter logic [21:0] MAKER_ID  = 22'h012345, // value is arbitrary
    parameter logic [5:0]  MODEL_NUM = 6'h15,      // value is arbitrary
    parameter logic [3:0]  REV_NUM   = 4'h2        // value is arbitrary
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        mdc,
    input  wire logic        mdio_i,
    output logic             mdio_o,
    output logic             mdio_oe_n,
    input  wire logic        loopback_pin,
    input  wire logic        shallow_loopback,
    input  wire logic        remote_loopback,
    input  wire logic        rate_fx,
    input  wire logic        sgmii_mode,
    input  wire logic        negotiation_done,
    input  wire logic        neg_link_up,
    input  wire logic        fx_link_mon,
    output logic             soft_reset,
    output logic             deep_loopback,
    output logic [15:0]      advert_word
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        pms_pkg::pms_mdio_st_e st;
        logic [4:0]            cnt;
        logic [15:0]           sh;
        logic                  wr_hit;
        logic [4:0]            reg_a;
        logic                  mdc_q;
        logic                  mdio_o;
        logic                  oe_n;
        logic [15:0]           adv;
        logic                  soft_rst;
        logic                  loop_ctl;
        logic                  deep_lb;
        logic [15:0]           adv_out;
    } pms_top_s;

    pms_top_s st_r;
    pms_top_s st_nxt;

    logic        mdc_s;
    logic        mdio_s;
    logic        loop_pin_s;
    logic        link_lat;
    logic        link_raw;
    logic        rd_clr;
    logic        mdc_rise;
    logic [15:0] stat_w;
    logic [15:0] id_high_w;
    logic [15:0] id_low_w;
    logic [11:0] hdr_w;
    logic [15:0] wdat_w;
    logic [15:0] rdat_w;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    pms_sync_2ff u_sync_mdc (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .pin_in   (mdc),
        .pin_sync (mdc_s)
    );

    pms_sync_2ff u_sync_mdio (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .pin_in   (mdio_i),
        .pin_sync (mdio_s)
    );

    pms_sync_2ff u_sync_loop (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .pin_in   (loopback_pin),
        .pin_sync (loop_pin_s)
    );

    // ****************************************************************
    // link status source and latch
    // ****************************************************************
    // remote loopback deliberately absent: the bit keeps its normal meaning
    always_comb begin
        if (st_r.deep_lb || shallow_loopback) begin
            link_raw = 1'b1; // R10
        end else if (rate_fx) begin
            link_raw = fx_link_mon; // R9
        end else begin
            link_raw = negotiation_done & neg_link_up; // R8
        end
    end

    pms_link_latch u_link (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .link_raw (link_raw),
        .rd_clr   (rd_clr),
        .link_lat (link_lat)
    );

    // ****************************************************************
    // read-only words
    // ****************************************************************
    always_comb begin
        stat_w                     = `PMS_STAT_FIXED; // R1 R2 R3 R4 R6 R7 R12
        stat_w[`PMS_STAT_DONE_BIT] = negotiation_done; // R5
        stat_w[`PMS_STAT_LINK_BIT] = link_lat; // R8
    end

    assign id_high_w = MAKER_ID[21:6]; // R13
    assign id_low_w  = {MAKER_ID[5:0], MODEL_NUM, REV_NUM}; // R13 R14

    assign mdc_rise = mdc_s & ~st_r.mdc_q;
    assign hdr_w    = {st_r.sh[10:0], mdio_s};
    assign wdat_w   = {st_r.sh[14:0], mdio_s};
    assign rd_clr   = mdc_rise && (st_r.st == pms_pkg::PMS_HDR)
                      && (st_r.cnt == `PMS_HDR_LAST)
                      && (hdr_w[11:10] == `PMS_OP_READ)
                      && (hdr_w[9:5] == PHY_ADDR)
                      && (hdr_w[4:0] == `PMS_REG_STATUS); // R11

    always_comb begin
        unique case (hdr_w[4:0])
            `PMS_REG_CONTROL: rdat_w = {st_r.soft_rst, st_r.loop_ctl, 14'h0000};
            `PMS_REG_STATUS:  rdat_w = stat_w;
            `PMS_REG_ID_HIGH: rdat_w = id_high_w;
            `PMS_REG_ID_LOW:  rdat_w = id_low_w;
            `PMS_REG_ADVERT:  rdat_w = st_r.adv; // R1
            default:          rdat_w = 16'h0000;
        endcase
    end

    // ****************************************************************
    // mdio frame engine and writable bits
    // ****************************************************************
    always_comb begin
        st_nxt       = st_r;
        st_nxt.mdc_q = mdc_s;
        // self-clear first so a fresh write in the same mdc cycle sticks
        if (mdc_rise && st_r.soft_rst) begin
            st_nxt.soft_rst = 1'b0; // R15
        end
        if (mdc_rise) begin
            unique case (st_r.st)
                pms_pkg::PMS_IDLE: begin
                    // no preamble needed: a zero on an idle line is a start
                    if (!mdio_s) begin
                        st_nxt.st = pms_pkg::PMS_START; // R4
                    end
                end
                pms_pkg::PMS_START: begin
                    if (mdio_s) begin
                        st_nxt.st  = pms_pkg::PMS_HDR;
                        st_nxt.cnt = 5'h00;
                    end
                end
                pms_pkg::PMS_HDR: begin
                    st_nxt.sh  = {st_r.sh[14:0], mdio_s};
                    st_nxt.cnt = st_r.cnt + 5'h01;
                    if (st_r.cnt == `PMS_HDR_LAST) begin
                        st_nxt.cnt    = 5'h00;
                        st_nxt.reg_a  = hdr_w[4:0];
                        st_nxt.wr_hit = (hdr_w[11:10] == `PMS_OP_WRITE)
                                        && (hdr_w[9:5] == PHY_ADDR);
                        if ((hdr_w[11:10] == `PMS_OP_READ)
                            && (hdr_w[9:5] == PHY_ADDR)) begin
                            st_nxt.st = pms_pkg::PMS_TA;
                            st_nxt.sh = rdat_w;
                        end else begin
                            st_nxt.st = pms_pkg::PMS_WDATA;
                        end
                    end
                end
                pms_pkg::PMS_TA: begin
                    st_nxt.oe_n   = 1'b0;
                    st_nxt.mdio_o = 1'b0;
                    st_nxt.st     = pms_pkg::PMS_RDATA;
                end
                pms_pkg::PMS_RDATA: begin
                    st_nxt.cnt = st_r.cnt + 5'h01;
                    if (st_r.cnt == `PMS_RD_LAST) begin
                        st_nxt.oe_n   = 1'b1;
                        st_nxt.mdio_o = 1'b0;
                        st_nxt.st     = pms_pkg::PMS_IDLE;
                    end else begin
                        st_nxt.mdio_o = st_r.sh[15];
                        st_nxt.sh     = {st_r.sh[14:0], 1'b0};
                    end
                end
                pms_pkg::PMS_WDATA: begin
                    // frames for another address or op are walked over here
                    st_nxt.sh  = wdat_w;
                    st_nxt.cnt = st_r.cnt + 5'h01;
                    if (st_r.cnt == `PMS_WR_LAST) begin
                        st_nxt.st = pms_pkg::PMS_IDLE;
                        if (st_r.wr_hit) begin
                            if (st_r.reg_a == `PMS_REG_CONTROL) begin
                                st_nxt.soft_rst =
                                    wdat_w[`PMS_CTL_RESET_BIT]; // R15
                                st_nxt.loop_ctl =
                                    wdat_w[`PMS_CTL_LOOP_BIT]; // R20
                            end
                            if (st_r.reg_a == `PMS_REG_ADVERT) begin
                                // R1 R16 R17 R18
                                st_nxt.adv = wdat_w & `PMS_ADV_WMASK;
                            end
                        end
                    end
                end
                default: begin
                    st_nxt.st = pms_pkg::PMS_IDLE;
                end
            endcase
        end
        st_nxt.deep_lb = st_r.loop_ctl | loop_pin_s; // R20
        if (sgmii_mode) begin
            st_nxt.adv_out = `PMS_ADV_SGMII; // R19
        end else begin
            st_nxt.adv_out = st_r.adv; // R16 R17
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r          <= '0;
            st_r.st       <= pms_pkg::PMS_IDLE;
            st_r.oe_n     <= 1'b1;
            st_r.adv      <= `PMS_ADV_RESET; // R16 R17 R18
            st_r.adv_out  <= `PMS_ADV_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign mdio_o        = st_r.mdio_o;
    assign mdio_oe_n     = st_r.oe_n;
    assign soft_reset    = st_r.soft_rst;
    assign deep_loopback = st_r.deep_lb;
    assign advert_word   = st_r.adv_out;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_status_zero_bits: assert property ( // R1
        (stat_w & 16'hBE82) == 16'h0000) else $error("status reserved set");
    chk_status_fixed_ones: assert property ( // R2
        (stat_w & 16'h4149) == 16'h4149) else $error("status fixed one low");
    chk_status_no_fault: assert property ( // R6
        !stat_w[4]) else $error("remote fault bit set");
    chk_done_mirror: assert property ( // R5
        stat_w[5] == negotiation_done) else $error("done bit mismatch");
    chk_fx_link_follow: assert property ( // R9
        (rate_fx && !st_r.deep_lb && !shallow_loopback && !fx_link_mon)
        |=> !link_lat) else $error("fx link loss missed");
    chk_loop_forces_link: assert property ( // R10
        (shallow_loopback && rd_clr) |=> link_lat)
        else $error("loopback did not force link");
    chk_soft_reset_clear: assert property ( // R15
        (soft_reset && mdc_rise && st_r.st != pms_pkg::PMS_WDATA)
        |=> !soft_reset) else $error("reset bit did not self clear");
    chk_sgmii_advert: assert property ( // R19
        sgmii_mode |=> advert_word == 16'h4001)
        else $error("sgmii advert wrong");
    chk_advert_follows: assert property ( // R16
        !sgmii_mode |=> advert_word == $past(st_r.adv))
        else $error("advert word not from register");
    chk_deep_loop_or: assert property ( // R20
        (loop_pin_s || st_r.loop_ctl) |=> deep_loopback)
        else $error("deep loopback not ored");
    chk_ident_fields: assert property ( // R14
        id_low_w[9:0] == {MODEL_NUM, REV_NUM}) else $error("ident wrong");
    chk_advert_reserved: assert property ( // R1
        (st_r.adv & 16'h4E1F) == 16'h0000) else $error("advert reserved set");
    chk_advert_reset_val: assert property (@(posedge ref_clk) // R18
        disable iff (1'b0)
        !rst_n |=> st_r.adv == 16'h0020) else $error("advert reset wrong");

    // ****************************************************************
    // frame engine and link source checks
    // ****************************************************************
    // the slave must never fight the station for the mdio line
    chk_ta_drive_zero: assert property (
        (mdc_rise && st_r.st == pms_pkg::PMS_TA)
        |=> (!mdio_oe_n && !mdio_o)) else $error("turnaround not zero");
    chk_rd_release: assert property (
        (mdc_rise && st_r.st == pms_pkg::PMS_RDATA
         && st_r.cnt == `PMS_RD_LAST) |=> mdio_oe_n)
        else $error("read did not release the line");
    chk_idle_released: assert property (
        (st_r.st == pms_pkg::PMS_IDLE) |-> mdio_oe_n)
        else $error("line driven while idle");
    chk_oe_only_read: assert property (
        !mdio_oe_n |-> (st_r.st == pms_pkg::PMS_RDATA))
        else $error("line driven outside read data");
    chk_loop_link_raw: assert property ( // R10
        (st_r.deep_lb || shallow_loopback) |-> link_raw)
        else $error("loopback did not force raw link");
    chk_remote_normal: assert property ( // R8 R10
        (!st_r.deep_lb && !shallow_loopback && !rate_fx)
        |-> (link_raw == (negotiation_done && neg_link_up)))
        else $error("1000x link source wrong");
    chk_fx_mirror: assert property ( // R9
        (!st_r.deep_lb && !shallow_loopback && rate_fx)
        |-> (link_raw == fx_link_mon)) else $error("fx link source wrong");
    chk_rd_rearm: assert property ( // R11
        (rd_clr && link_raw) |=> link_lat)
        else $error("status read did not re-arm link");

    // commit point of an addressed write, shared by the next four checks
    logic wr_last;
    assign wr_last = mdc_rise && (st_r.st == pms_pkg::PMS_WDATA)
                     && (st_r.cnt == `PMS_WR_LAST) && st_r.wr_hit;

    chk_adv_write_mask: assert property ( // R16 R17 R18
        (wr_last && st_r.reg_a == `PMS_REG_ADVERT)
        |=> (st_r.adv == ($past(wdat_w) & `PMS_ADV_WMASK)))
        else $error("advert write not masked");
    chk_soft_reset_set: assert property ( // R15
        (wr_last && st_r.reg_a == `PMS_REG_CONTROL)
        |=> (soft_reset == $past(wdat_w[`PMS_CTL_RESET_BIT])))
        else $error("reset bit write lost");
    chk_loop_ctl_write: assert property ( // R20
        (wr_last && st_r.reg_a == `PMS_REG_CONTROL)
        |=> (st_r.loop_ctl == $past(wdat_w[`PMS_CTL_LOOP_BIT])))
        else $error("loopback bit write lost");
    chk_adv_hold: assert property ( // R16
        !(wr_last && st_r.reg_a == `PMS_REG_ADVERT) |=> $stable(st_r.adv))
        else $error("advert changed without write");
    chk_deep_loop_off: assert property ( // R20
        (!loop_pin_s && !st_r.loop_ctl) |=> !deep_loopback)
        else $error("deep loopback stuck");
endmodule
`default_nettype wire

// ===== pms_sta_model.sv
// mdio station manager model: clocks mdc, drives and reads mdio
// assumes the bench resolves mdio with a pull-up when nobody drives
`timescale 1ns/10ps
`default_nettype none
module pms_sta_model (
    output logic      mdc,
    output logic      mdio_drv,
    output logic      mdio_en,
    input  wire logic mdio_lvl
);
    // ******************************
    // bit cycles
    // ******************************
    // mdc stands low between frames, so no stray edge reaches the slave
    localparam realtime HALF = 62.5;

    initial begin
        mdc      = 1'b0;
        mdio_drv = 1'b0;
        mdio_en  = 1'b0;
    end

    task automatic put_bit(input logic b);
        mdio_en  = 1'b1;
        mdio_drv = b;
        #HALF mdc = 1'b1;
        #HALF mdc = 1'b0;
    endtask

    // sample just before the rise, long after the slave moved its bit
    task automatic get_bit(output logic b);
        mdio_en = 1'b0;
        #HALF b = mdio_lvl;
        mdc = 1'b1;
        #HALF mdc = 1'b0;
    endtask

    // line released, pull-up gives ones
    task automatic idle_clk(input int n);
        logic b;
        #1;
        repeat (n) get_bit(b);
    endtask

    // ******************************
    // whole frames
    // ******************************
    task automatic frame(input int npre, input logic [1:0] op,
                         input logic [4:0] phy, input logic [4:0] rg,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [13:0] hdr;
        logic        b;
        // step off the ref_clk edge that the caller returns on
        #1;
        hdr = {2'h1, op, phy, rg};
        rd  = 16'h0000;
        for (int i = 0; i < npre; i++) put_bit(1'b1);
        for (int i = 13; i >= 0; i--) put_bit(hdr[i]);
        if (op == 2'h2) begin
            get_bit(b);
            get_bit(b);
            for (int i = 15; i >= 0; i--) get_bit(rd[i]);
        end else begin
            put_bit(1'b1);
            put_bit(1'b0);
            for (int i = 15; i >= 0; i--) put_bit(wd[i]);
        end
        mdio_en = 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== pms_mgmt_regs_tb.sv
// self-checking bench of the channel management register set
// assumes the station model owns mdc/mdio; the rest is driven here
`timescale 1ns/10ps
`default_nettype none
module pms_mgmt_regs_tb;
    typedef struct packed {
        logic [7:0]  ins;
        logic [4:0]  rg;
        logic [15:0] exp;
    } pms_row_s;

    localparam logic [4:0]  ADDR    = 5'h13;
    localparam logic [21:0] MID     = 22'h2A5C3F; // value is arbitrary
    localparam logic [5:0]  MODEL_V = 6'h2B;      // value is arbitrary
    localparam logic [3:0]  REV_V   = 4'h9;       // value is arbitrary

    logic        ref_clk, rst_n, mdc, mdio_lvl, mdio_o, mdio_oe_n;
    logic        m_drv, m_en, soft_reset, deep_loopback;
    logic        loopback_pin, shallow_loopback, remote_loopback, rate_fx;
    logic        sgmii_mode, negotiation_done, neg_link_up, fx_link_mon;
    logic [15:0] advert_word, d;
    int          n_fail = 0;
    int          num_checks = 0;
    pms_row_s    rows [0:11];

    pms_mgmt_regs #(
        .PHY_ADDR  (ADDR),
        .MAKER_ID  (MID),
        .MODEL_NUM (MODEL_V),
        .REV_NUM   (REV_V)
    ) dut_u (
        .ref_clk          (ref_clk),
        .rst_n            (rst_n),
        .mdc              (mdc),
        .mdio_i           (mdio_lvl),
        .mdio_o           (mdio_o),
        .mdio_oe_n        (mdio_oe_n),
        .loopback_pin     (loopback_pin),
        .shallow_loopback (shallow_loopback),
        .remote_loopback  (remote_loopback),
        .rate_fx          (rate_fx),
        .sgmii_mode       (sgmii_mode),
        .negotiation_done (negotiation_done),
        .neg_link_up      (neg_link_up),
        .fx_link_mon      (fx_link_mon),
        .soft_reset       (soft_reset),
        .deep_loopback    (deep_loopback),
        .advert_word      (advert_word)
    );
    pms_sta_model sta_u (
        .mdc      (mdc),
        .mdio_drv (m_drv),
        .mdio_en  (m_en),
        .mdio_lvl (mdio_lvl)
    );
    // pull-up wins when neither end drives
    assign mdio_lvl = !mdio_oe_n ? mdio_o : (m_en ? m_drv : 1'b1);

    always #4 ref_clk = ~ref_clk;

    // ******************************
    // shared tasks
    // ******************************
    task automatic end_of_test;
        if (n_fail == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic drive(input logic [7:0] v);
        {remote_loopback, shallow_loopback, loopback_pin, rate_fx,
         sgmii_mode, negotiation_done, neg_link_up, fx_link_mon} = v;
    endtask

    task automatic set_in(input logic [7:0] v);
        @(posedge ref_clk);
        #1 drive(v);
        repeat (10) @(posedge ref_clk);
    endtask

    task automatic rd(input logic [4:0] rg, output logic [15:0] v);
        sta_u.frame(0, 2'h2, ADDR, rg, 16'h0000, v);
    endtask

    task automatic wr(input logic [4:0] rg, input logic [15:0] v);
        logic [15:0] unused;
        sta_u.frame(0, 2'h1, ADDR, rg, v, unused);
        repeat (10) @(posedge ref_clk);
    endtask

    task automatic do_reset;
        @(posedge ref_clk);
        #1 rst_n = 1'b0;
        repeat (5) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        repeat (5) @(posedge ref_clk);
    endtask

    // ******************************
    // watchdog
    // ******************************
    // about three times the expected run
    initial begin
        #600000;
        n_fail++;
        end_of_test;
    end

    // ******************************
    // main sequence
    // ******************************
    initial begin
        ref_clk = 1'b0;
        rst_n   = 1'b0;
        drive(8'h00);
        // ins: remote shallow pin fx sgmii done link fxmon
        rows = '{
            {8'h06, 5'h01, 16'h416D},
            {8'h02, 5'h01, 16'h4149},
            {8'h04, 5'h01, 16'h4169},
            {8'h11, 5'h01, 16'h414D},
            {8'h16, 5'h01, 16'h4169},
            {8'h40, 5'h01, 16'h414D},
            {8'h20, 5'h01, 16'h414D},
            {8'h80, 5'h01, 16'h4149},
            {8'h00, 5'h02, MID[21:6]},
            {8'h00, 5'h03, {MID[5:0], MODEL_V, REV_V}},
            {8'h00, 5'h04, 16'h0020},
            {8'h00, 5'h09, 16'h0000}
        };
        do_reset;
        // first read re-arms the latched link bit
        for (int i = 0; i < 12; i++) begin
            set_in(rows[i].ins);
            rd(rows[i].rg, d);
            rd(rows[i].rg, d);
            check(d, rows[i].exp);
            check({15'h0000, deep_loopback}, {15'h0000, rows[i].ins[5]});
        end
        // other address: line left to the pull-up
        sta_u.frame(0, 2'h2, ADDR ^ 5'h01, 5'h01, 16'h0000, d);
        check(d, 16'hFFFF);
        sta_u.frame(32, 2'h2, ADDR, 5'h02, 16'h0000, d);
        check(d, MID[21:6]);
        wr(5'h04, 16'hFFFF);
        rd(5'h04, d);
        check(d, 16'hB1E0);
        check(advert_word, 16'hB1E0);
        for (int rf = 0; rf < 4; rf++) begin
            wr(5'h04, 16'h4E1F | (16'(rf) << 12));
            rd(5'h04, d);
            check(d, 16'(rf) << 12);
            check(advert_word, 16'(rf) << 12);
        end
        set_in(8'h08);
        check(advert_word, 16'h4001);
        set_in(8'h00);
        check(advert_word, 16'h3000);
        do_reset;
        check(advert_word, 16'h0020);
        check({13'h0000, soft_reset, deep_loopback, mdio_oe_n}, 16'h0001);
        rd(5'h01, d);
        check(d, 16'h4149);
        set_in(8'h06);
        rd(5'h01, d);
        check(d, 16'h4169);
        rd(5'h01, d);
        check(d, 16'h416D);
        // short loss must stay visible until read
        set_in(8'h04);
        set_in(8'h06);
        rd(5'h01, d);
        check(d, 16'h4169);
        rd(5'h01, d);
        check(d, 16'h416D);
        wr(5'h01, 16'h0000);
        wr(5'h02, ~MID[21:6]);
        wr(5'h03, 16'h0000);
        rd(5'h01, d);
        check(d, 16'h416D);
        rd(5'h02, d);
        check(d, MID[21:6]);
        rd(5'h03, d);
        check(d, {MID[5:0], MODEL_V, REV_V});
        set_in(8'h04);
        wr(5'h00, 16'h4000);
        check({15'h0000, deep_loopback}, 16'h0001);
        rd(5'h01, d);
        rd(5'h01, d);
        check(d, 16'h416D);
        wr(5'h00, 16'h0000);
        check({15'h0000, deep_loopback}, 16'h0000);
        wr(5'h00, 16'h8000);
        check({15'h0000, soft_reset}, 16'h0001);
        sta_u.idle_clk(1);
        repeat (10) @(posedge ref_clk);
        check({15'h0000, soft_reset}, 16'h0000);
        end_of_test;
    end
endmodule
`default_nettype wire
